/* core/acc_pkg.sv */
// Overview of operation
// - writing one to the start flag begins one conversion cycle.
// - hardware clears the start flag when the conversion finishes.
// - start flag reads one while converting, zero otherwise.
// - converter-on bit enables converter; zero gates it off completely.
// - analog inputs on oscillator pins disabled when system clock is external.
// - five-bit field selects which internal source auto-starts a conversion.
// - auto-trigger sources start conversions only on a rising edge.
// - upper three auto-trigger register bits read zero, writes ignored.
// - alignment one gives right-justified result, top two bits in high byte.
// - alignment zero gives left-justified result, low two bits in bits 7-6.
package acc_pkg;
    localparam logic [3:0] OFS_CTRL0    = 4'h0;
    localparam logic [3:0] OFS_CTRL1    = 4'h4;
    localparam logic [3:0] OFS_TRIG     = 4'h8;
    localparam logic [3:0] OFS_RESH     = 4'hc;
    localparam logic [4:0] OFS_RESL     = 5'h10;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

    localparam int BIT_ON       = 0;
    localparam int BIT_GO       = 1;
    localparam int BIT_ALIGN    = 7;
    localparam int POS_CLKSEL   = 4;
    localparam int POS_PREF     = 0;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_TRIGGER  = 1;

    localparam logic [7:0] RST_CTRL0    = 8'h00;
    localparam logic [7:0] RST_CTRL1    = 8'h00;
    localparam logic [7:0] RST_TRIG     = 8'h00;
    localparam logic [7:0] MASK_CTRL1   = 8'hf3;
    localparam logic [7:0] MASK_TRIG    = 8'h1f;
    localparam logic [1:0] MASK_IRQ     = 2'h3;

    localparam int CONV_TAD   = 12;
    localparam int RC_DIV     = 8;

    localparam logic [1:0] PREF_SUPPLY   = 2'h0;
    localparam logic [1:0] PREF_RESERVED = 2'h1;
    localparam logic [1:0] PREF_EXTPIN   = 2'h2;
    localparam logic [1:0] PREF_FIXED    = 2'h3;

    typedef enum logic [1:0] {
        ACC_IDLE   = 2'b00,
        ACC_SAMPLE = 2'b01,
        ACC_CONV   = 2'b11
    } acc_state_t;
endpackage

/* core/acc_clk_if.sv */
`timescale 1ns/1ns
interface acc_clk_if;
    logic [2:0] clock_select;
    logic       run;
    logic       tick;
    modport ctrl (output clock_select, output run, input tick);
    modport gen  (input clock_select, input run, output tick);
endinterface

/* core/acc_clkgen.sv */
`timescale 1ns/1ns
module acc_clkgen #(
    parameter int RC_DIVIDE = acc_pkg::RC_DIV
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    acc_clk_if.gen     cif
);
    logic [6:0] cnt;
    logic [6:0] limit;

    // divide codes: 000 /2, 001 /8, 010 /32, 100 /4, 101 /16, 110 /64, x11 rc
    always_comb begin
        unique case (cif.clock_select)
            3'h0:    limit = 7'h01;
            3'h1:    limit = 7'h07;
            3'h2:    limit = 7'h1f;
            3'h4:    limit = 7'h03;
            3'h5:    limit = 7'h0f;
            3'h6:    limit = 7'h3f;
            default: limit = 7'(RC_DIVIDE - 1);
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !cif.run || cnt >= limit) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end

    assign cif.tick = cif.run && (cnt == limit);
endmodule

/* core/acc_top.sv */
`timescale 1ns/1ns
module acc_top #(
    parameter int NUM_TRIG = 32
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [4:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [NUM_TRIG-1:0] trig_i,
    input  wire logic                sys_clk_external_i,
    input  wire logic                cmp_bit_i,
    output logic                     converter_on_o,
    output logic                     sample_o,
    output logic [9:0]               sar_code_o,
    output logic [1:0]               positive_ref_select_o,
    output logic                     osc_pin_analog_disable_o,
    output logic                     irq_o
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [7:0]  trig_sel;
    logic [9:0]  result;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [NUM_TRIG-1:0] trig_s1;
    logic [NUM_TRIG-1:0] trig_s2;
    logic [NUM_TRIG-1:0] trig_s3;
    logic        ext_s1;
    logic        ext_s2;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        trig_rise;
    logic        go_write;
    logic        done;
    logic        step;
    logic        sar_load;
    logic [1:0]  settle;
    logic        wr;
    logic [3:0]  tad_cnt;
    logic [3:0]  bit_idx;
    logic [9:0]  sar;
    acc_pkg::acc_state_t state;
    acc_clk_if   cif ();

    // writes land on the ack edge, while the master still holds its request
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////
    // bus: one wait state, ack drops the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            unique case (wb_adr_i)
                5'(acc_pkg::OFS_CTRL0):    wb_dat_o <= {24'h0, ctrl0};
                5'(acc_pkg::OFS_CTRL1):    wb_dat_o <= {24'h0, ctrl1};
                5'(acc_pkg::OFS_TRIG):     wb_dat_o <= {24'h0, trig_sel};
                5'(acc_pkg::OFS_RESH):     wb_dat_o <= {24'h0, align_hi(result, ctrl1)};
                acc_pkg::OFS_RESL:         wb_dat_o <= {24'h0, align_lo(result, ctrl1)};
                acc_pkg::OFS_IRQ_STAT:     wb_dat_o <= {30'h0, irq_stat};
                acc_pkg::OFS_IRQ_MASK:     wb_dat_o <= {30'h0, irq_mask};
                default:                   wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    function automatic logic [7:0] align_hi(input logic [9:0] r, input logic [7:0] c1);
        if (c1[acc_pkg::BIT_ALIGN]) begin
            align_hi = {6'h00, r[9:8]};
        end else begin
            align_hi = r[9:2];
        end
    endfunction

    function automatic logic [7:0] align_lo(input logic [9:0] r, input logic [7:0] c1);
        if (c1[acc_pkg::BIT_ALIGN]) begin
            align_lo = r[7:0];
        end else begin
            align_lo = {r[1:0], 6'h00};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1    <= acc_pkg::RST_CTRL1;
            trig_sel <= acc_pkg::RST_TRIG;
        end else if (wr && wb_adr_i == 5'(acc_pkg::OFS_CTRL1)) begin
            ctrl1 <= wb_dat_i[7:0] & acc_pkg::MASK_CTRL1;
        end else if (wr && wb_adr_i == 5'(acc_pkg::OFS_TRIG)) begin
            trig_sel <= wb_dat_i[7:0] & acc_pkg::MASK_TRIG;
        end
    end

    assign go_write = wr && wb_adr_i == 5'(acc_pkg::OFS_CTRL0) && wb_dat_i[acc_pkg::BIT_GO];

    // go flag: set by software or trigger, cleared by hardware at done
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0 <= acc_pkg::RST_CTRL0;
        end else begin
            if (wr && wb_adr_i == 5'(acc_pkg::OFS_CTRL0)) begin
                ctrl0[7:2]             <= wb_dat_i[7:2];
                ctrl0[acc_pkg::BIT_ON] <= wb_dat_i[acc_pkg::BIT_ON];
            end
            if (done) begin
                ctrl0[acc_pkg::BIT_GO] <= 1'b0;
            end
            // a start only counts with the converter on
            if ((go_write || trig_rise) && converter_on_o && state == acc_pkg::ACC_IDLE) begin
                ctrl0[acc_pkg::BIT_GO] <= 1'b1;
            end
            if (wr && wb_adr_i == 5'(acc_pkg::OFS_CTRL0) && !wb_dat_i[acc_pkg::BIT_ON]) begin
                ctrl0[acc_pkg::BIT_GO] <= 1'b0;
            end
        end
    end

    assign converter_on_o = ctrl0[acc_pkg::BIT_ON];
    assign positive_ref_select_o = ctrl1[acc_pkg::POS_PREF +: 2];

    ////////////////////////////////////////////////////////////////////
    // trigger sources and pins come from other domains
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_s1 <= '0;
            trig_s2 <= '0;
            trig_s3 <= '0;
            ext_s1  <= 1'b0;
            ext_s2  <= 1'b0;
            cmp_s1  <= 1'b0;
            cmp_s2  <= 1'b0;
        end else begin
            trig_s1 <= trig_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            ext_s1  <= sys_clk_external_i;
            ext_s2  <= ext_s1;
            cmp_s1  <= cmp_bit_i;
            cmp_s2  <= cmp_s1;
        end
    end

    // selector code 0 means no auto trigger
    assign trig_rise = (trig_sel[4:0] != 5'h00)
                       && trig_s2[trig_sel[4:0]] && !trig_s3[trig_sel[4:0]];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_pin_analog_disable_o <= 1'b0;
        end else begin
            osc_pin_analog_disable_o <= ext_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer, one tad per step, two tads per step at the fastest tad
    assign cif.clock_select = ctrl1[acc_pkg::POS_CLKSEL +: 3];
    assign cif.run          = converter_on_o && state != acc_pkg::ACC_IDLE;

    acc_clkgen u_clkgen (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cif   (cif)
    );

    // a decision waits until the comparator has crossed its synchroniser:
    // the fastest tad is shorter than that, so such steps stretch
    assign step     = state == acc_pkg::ACC_CONV && cif.tick && settle[1];
    assign done     = step && bit_idx == 4'h0;
    assign sar_load = (state == acc_pkg::ACC_SAMPLE && cif.tick
                       && tad_cnt == 4'(acc_pkg::CONV_TAD - 11)) || step;

    always_ff @(posedge clk_i) begin
        if (rst_i || sar_load) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !converter_on_o) begin
            state   <= acc_pkg::ACC_IDLE;
            tad_cnt <= 4'h0;
            bit_idx <= 4'h9;
            sar     <= 10'h000;
        end else begin
            unique case (state)
                acc_pkg::ACC_IDLE: begin
                    if (ctrl0[acc_pkg::BIT_GO]) begin
                        state   <= acc_pkg::ACC_SAMPLE;
                        tad_cnt <= 4'h0;
                    end
                end
                acc_pkg::ACC_SAMPLE: begin
                    if (cif.tick) begin
                        tad_cnt <= tad_cnt + 4'h1;
                        if (tad_cnt == 4'(acc_pkg::CONV_TAD - 11)) begin
                            state   <= acc_pkg::ACC_CONV;
                            bit_idx <= 4'h9;
                            sar     <= 10'h200;
                        end
                    end
                end
                acc_pkg::ACC_CONV: begin
                    if (step) begin
                        // keep the trial bit when the comparator says input is above
                        sar[bit_idx] <= cmp_s2;
                        if (bit_idx != 4'h0) begin
                            sar[bit_idx - 4'h1] <= 1'b1;
                            bit_idx <= bit_idx - 4'h1;
                        end else begin
                            state <= acc_pkg::ACC_IDLE;
                        end
                    end
                end
                default: state <= acc_pkg::ACC_IDLE;
            endcase
        end
    end

    assign sample_o   = state == acc_pkg::ACC_SAMPLE;
    assign sar_code_o = sar;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result <= 10'h000;
        end else if (done) begin
            result <= {sar[9:1], cmp_s2};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts: write one to clear, a fresh event beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
        end else begin
            if (wr && wb_adr_i == acc_pkg::OFS_IRQ_MASK) begin
                irq_mask <= wb_dat_i[1:0] & acc_pkg::MASK_IRQ;
            end
            irq_stat <= (irq_stat
                         & ~((wr && wb_adr_i == acc_pkg::OFS_IRQ_STAT) ? wb_dat_i[1:0] : 2'h0))
                        | {trig_rise, done};
        end
    end

    assign irq_o = |(irq_stat & irq_mask);
endmodule

/* tb/acc_core_model.sv */
`timescale 1ns/1ns
module acc_core_model #(
    parameter logic [9:0] LEVEL = 10'h2b5
) (
    input  wire logic [9:0] sar_code_i,
    input  wire logic       powered_i,
    output logic            cmp_bit_o
);
    // an unpowered core decides nothing, so every trial bit is dropped
    assign cmp_bit_o = powered_i && (sar_code_i <= LEVEL);
endmodule

/* tb/acc_checker.sv */
`timescale 1ns/1ns
module acc_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sys_clk_external_i,
    input wire logic        converter_on_o,
    input wire logic        sample_o,
    input wire logic [1:0]  positive_ref_select_o,
    input wire logic        osc_pin_analog_disable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd;
    logic wr;
    assign rd = wb_ack_o && !wb_we_i;
    assign wr = wb_ack_o && wb_we_i;
    ////////////////////////////////////////
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle");
    go_read_a: assert property (rd && wb_adr_i == 5'h00 && $past(sample_o) |-> wb_dat_o[1])
        else $error("start flag low while converting");
    osc_disable_a: assert property (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
        |-> osc_pin_analog_disable_o == $past(sys_clk_external_i, 3))
        else $error("oscillator pin disable wrong");
    idle_off_a: assert property (!converter_on_o && !$past(converter_on_o) |-> !sample_o)
        else $error("sampling while converter off");
    on_write_a: assert property (!$past(rst_i) && $changed(converter_on_o)
        |-> $past(wr && wb_adr_i == 5'h00))
        else $error("enable changed without a write");
    ref_write_a: assert property (!$past(rst_i) && $changed(positive_ref_select_o)
        |-> $past(wr && wb_adr_i == 5'h04))
        else $error("reference changed without a write");
    trig_read_a: assert property (rd && wb_adr_i == 5'h08 |-> wb_dat_o[31:5] == 27'h0)
        else $error("trigger select upper bits not zero");
    ctrl1_read_a: assert property (rd && wb_adr_i == 5'h04 |-> wb_dat_o[3:2] == 2'h0
        && wb_dat_o[1:0] == positive_ref_select_o)
        else $error("control one read wrong");
    sample_on_a: assert property ($rose(sample_o) |-> converter_on_o)
        else $error("conversion started while off");
endmodule

bind acc_top acc_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .sys_clk_external_i, .converter_on_o, .sample_o,
    .positive_ref_select_o, .osc_pin_analog_disable_o);

/* tb/adc_conversion_control_tb.sv */
`timescale 1ns/1ns
module adc_conversion_control_tb;
    localparam logic [9:0] LEVEL = 10'h2b5;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [4:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack;
    logic [31:0] trig;
    logic        ext;
    logic        cmp;
    logic        on;
    logic        irq;
    logic        osc;
    logic [1:0]  pref;
    logic [9:0]  code;
    int          failures;
    int          cmp_count;

    acc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .trig_i(trig), .sys_clk_external_i(ext), .cmp_bit_i(cmp), .converter_on_o(on),
        .sample_o(), .sar_code_o(code), .positive_ref_select_o(pref),
        .osc_pin_analog_disable_o(osc), .irq_o(irq));
    acc_core_model #(.LEVEL(LEVEL)) core (.sar_code_i(code), .powered_i(on), .cmp_bit_o(cmp));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail(input string msg);
        failures++;
        $display("ERROR %0t %s", $time, msg);
    endtask
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
    endtask
    // got is taken at the call, so callers look only at settled outputs
    task automatic chk_pin(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("pin %b expected %b", got, exp));
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        if (ack !== 1'b1) begin
            fail("no bus answer");
            wrap_up();
        end else begin
            // the write lands on the ack edge; let its effects settle
            @(posedge clk_i);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk_data(rdat, exp);
    endtask
    // bounded poll: a flag that never arrives ends the run
    task automatic poll_go(input logic exp);
        int n;
        for (n = 0; n < 60; n++) begin
            bus(1'b0, 5'h00, 8'h00);
            if (rdat[1] === exp) break;
        end
        chk_pin(rdat[1], exp);
        if (n == 60) wrap_up();
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        logic [4:0] addrs [4] = '{5'h00, 5'h04, 5'h08, 5'h1c};
        foreach (addrs[i]) rd_chk(addrs[i], 32'h0);
        chk_pin(on, 1'b0);
    endtask
    task automatic t_regs();
        bus(1'b1, 5'h08, 8'hff);
        rd_chk(5'h08, 32'h1f);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 5'h04, 8'(i * 17) | 8'h0c);
            rd_chk(5'h04, {24'h0, 8'(i * 17) & 8'hf3});
            chk_pin(pref[0], i[0]);
            chk_pin(pref[1], i[1]);
        end
    endtask
    task automatic t_conv(input logic al);
        bus(1'b1, 5'h04, {al, 7'h00});
        bus(1'b1, 5'h00, 8'h01);
        bus(1'b1, 5'h00, 8'h03);
        chk_pin(on, 1'b1);
        poll_go(1'b1);
        poll_go(1'b0);
        rd_chk(5'h0c, al ? {30'h0, LEVEL[9:8]} : {24'h0, LEVEL[9:2]});
        rd_chk(5'h10, al ? {24'h0, LEVEL[7:0]} : {24'h0, LEVEL[1:0], 6'h0});
        chk_pin(irq, 1'b0);
        bus(1'b1, 5'h18, 8'h01);
        chk_pin(irq, 1'b1);
        bus(1'b1, 5'h14, 8'h01);
        chk_pin(irq, 1'b0);
        bus(1'b1, 5'h18, 8'h00);
    endtask
    task automatic t_trig();
        bus(1'b1, 5'h08, 8'h05);
        trig <= 32'h40;
        repeat (4) @(posedge clk_i);
        rd_chk(5'h00, 32'h01);
        trig <= 32'h60;
        poll_go(1'b1);
        poll_go(1'b0);
        repeat (40) @(posedge clk_i);
        rd_chk(5'h00, 32'h01);
        trig <= 32'h0;
    endtask
    task automatic t_off();
        bus(1'b1, 5'h00, 8'h03);
        bus(1'b1, 5'h00, 8'h00);
        rd_chk(5'h00, 32'h0);
        bus(1'b1, 5'h00, 8'h02);
        rd_chk(5'h00, 32'h0);
        ext <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk_pin(osc, 1'b1);
        ext <= 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        failures = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        wdat = 32'h0;
        sel = 4'h0;
        trig = 32'h0;
        ext = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        $display("t_reset done");
        t_regs();
        $display("t_regs done");
        t_conv(1'b1);
        t_conv(1'b0);
        $display("t_conv done");
        t_trig();
        $display("t_trig done");
        t_off();
        $display("t_off done");
        wrap_up();
    end
endmodule
